// ---- hdl/swp_sector_protect.sv ----
// swp_sector_protect: sector group write protection with apb register access
//
// Functional notes
// - one volatile dynamic bit per group
// - dynamic bit matters only if persistent bit 0
// - set protects, clear unprotects, repeatable
// - dynamic bits cleared on power-up and reset
// - lock and persistent bits come up cleared
// - unprotected only when both bits zero
// - lock refuses persistent changes, not dynamic
// - outside password mode only reset clears lock
// - password mode sets lock after reset
// - exact password match clears lock
// - password programming only clears bits, else timeout
// - password programming forces status reads until read-reset
// - password mode lock hides and freezes password
// - two microsecond delay per password check
// - write-protect low guards two boot sectors
// - write-protect high follows protection bits
// - power-up resets to idle, inhibits early writes (here the inhibit ends on the first clock after presetn)
// - write cycle needs ce, we low, oe high
// - protected target: no change, poll then idle
// - lock one freezes persistent bits
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module swp_sector_protect #(
   parameter int unsigned ERASE_POLL = swp_pkg::ERASE_POLL_CYC
) (
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [7:0]                     paddr,
   input  wire logic [31:0]                    pwdata,
   output var  logic [31:0]                    prdata,
   output var  logic                           pready,
   output var  logic                           pslverr,
   input  wire logic                           ce_n,
   input  wire logic                           we_n,
   input  wire logic                           oe_n,
   input  wire logic                           wp_n,
   input  wire logic                           reset_pin_n,
   output var  logic                           op_grant,
   output var  logic                           op_erase,
   output var  logic [swp_pkg::GRP_W-1:0]      op_group,
   output var  logic                           status_poll,
   output var  logic                           status_read_mode
);
   import swp_pkg::*;

   localparam logic [CNT_W-1:0] CHK_CNT  = CNT_W'(PW_CHECK_CYC - 1);
   localparam logic [CNT_W-1:0] PRG_CNT  = CNT_W'(PROG_POLL_CYC - 1);
   localparam logic [CNT_W-1:0] ERA_CNT  = CNT_W'(ERASE_POLL - 1);

   swp_regs_t r;
   swp_regs_t next_r;
   logic [NPINS-1:0] pins;

   assign pins = {reset_pin_n, wp_n, oe_n, we_n, ce_n};

   // address to sector group: eight 8-kbyte boot groups, then 64-kbyte groups
   function automatic logic [GRP_W-1:0] addr_to_group(input logic [ADDR_W-1:0] a);
      logic [GRP_W-1:0] g;
      g = '0;
      if (a < BOOT_END) begin
         g = {2'b00, a[15:13]};
      end else begin
         g = {1'b0, a[19:16]} + MAIN_GRP_OFS;
      end
      return g;
   endfunction : addr_to_group

   function automatic logic is_boot_wp(input logic [GRP_W-1:0] g);
      return (g == WP_GRP_A) || (g == WP_GRP_B);
   endfunction : is_boot_wp

   function automatic logic [NUM_GROUPS-1:0] prot_vec(input swp_regs_t s);
      logic [NUM_GROUPS-1:0] v;
      v = s.pers | s.dyn;
      if (!s.s2[PIN_WP]) begin
         v[WP_GRP_A] = 1'b1;
         v[WP_GRP_B] = 1'b1;
      end
      return v;
   endfunction : prot_vec

   function automatic logic is_mapped(input logic [7:0] a);
      logic m;
      m = 1'b0;
      case (a)
         OFS_CMD, OFS_ADDR, OFS_PWD_LO, OFS_PWD_HI, OFS_STATUS,
         OFS_DYN, OFS_PERS, OFS_PROT, OFS_PWRD_LO, OFS_PWRD_HI: m = 1'b1;
         default: m = 1'b0;
      endcase
      return m;
   endfunction : is_mapped

   always_comb begin
      logic              wcyc;
      logic              ce_ok;
      logic              rst_lo;
      logic [31:0]       rd;
      logic [GRP_W-1:0]  tg;
      logic [NUM_GROUPS-1:0] pv;
      next_r = r;
      pv     = '0;
      wcyc   = 1'b0;
      ce_ok  = 1'b0;
      rst_lo = 1'b0;
      rd     = '0;
      tg     = '0;

      // pin synchronisers
      next_r.s1       = pins;
      next_r.s2       = r.s1;
      next_r.we_q     = r.s2[PIN_WE];
      next_r.gnt.grant = 1'b0;

      // we rising edge ends a write cycle; ce low and oe high qualify it
      ce_ok = !r.s2[PIN_CE] && r.s2[PIN_OE];
      wcyc  = ce_ok && r.s2[PIN_WE] && !r.we_q;
      // power-up inhibit ends on the first cycle without ce_ok, we low and reset pin low together
      if (r.pu_inh && !(ce_ok && !r.s2[PIN_WE] && !r.s2[PIN_RS])) begin
         next_r.pu_inh = 1'b0;
      end
      if (r.pu_inh) begin
         wcyc = 1'b0;
      end

      // apb register access, one wait state
      if (psel && penable && !r.pready) begin
         next_r.pready  = 1'b1;
         next_r.pslverr = !is_mapped(paddr);
         case (paddr)
            OFS_CMD:    rd = {19'h0, r.cgrp, 4'h0, r.op};
            OFS_ADDR:   rd = {12'h0, r.addr};
            OFS_STATUS: begin
               rd[ST_BUSY]    = (r.state != ST_IDLE);
               rd[ST_POLL]    = (r.state != ST_IDLE);
               rd[ST_DENIED]  = r.denied;
               rd[ST_TIMEOUT] = r.tmo;
               rd[ST_LOCK]    = r.lock;
               rd[ST_PW_MODE] = r.pw_mode;
               rd[ST_PW_LOCK] = r.pw_lock;
               rd[ST_STAT_RD] = r.stat_rd;
               rd[ST_PU_INH]  = r.pu_inh;
               rd[ST_PEND]    = r.pend;
            end
            OFS_DYN:    rd = r.dyn;
            OFS_PERS:   rd = r.pers;
            OFS_PROT:   rd = prot_vec(r);
            OFS_PWRD_LO: rd = r.pw_lock ? 32'h0 : r.pw[31:0];
            OFS_PWRD_HI: rd = r.pw_lock ? 32'h0 : r.pw[63:32];
            default:    rd = '0;
         endcase
         next_r.prdata = rd;
      end else if (psel && penable && r.pready) begin
         next_r.pready  = 1'b0;
         next_r.pslverr = 1'b0;
         if (pwrite) begin
            case (paddr)
               OFS_CMD: begin
                  next_r.op   = swp_op_t'(pwdata[CMD_OP_LSB +: 4]);
                  next_r.cgrp = pwdata[CMD_GRP_LSB +: GRP_W];
                  next_r.pend = 1'b1;
               end
               OFS_ADDR:   next_r.addr = pwdata[ADDR_W-1:0];
               OFS_PWD_LO: next_r.pwd_in[31:0] = pwdata;
               OFS_PWD_HI: next_r.pwd_in[63:32] = pwdata;
               default: ;
            endcase
         end
      end

      // command engine
      case (r.state)
         ST_IDLE: begin
            if (wcyc && r.pend) begin
               next_r.pend   = 1'b0;
               next_r.denied = 1'b0;
               next_r.tmo    = 1'b0;
               case (r.op)
                  OP_DYN_SET: next_r.dyn[r.cgrp] = 1'b1;
                  OP_DYN_CLR: next_r.dyn[r.cgrp] = 1'b0;
                  OP_PERS_PROG: begin
                     if (r.lock) begin
                        next_r.tmo = 1'b1;
                     end else begin
                        next_r.pers[r.cgrp] = 1'b1;
                     end
                  end
                  OP_PERS_ERA: begin
                     if (r.lock) begin
                        next_r.tmo = 1'b1;
                     end else begin
                        next_r.pers = BITS_RESET;
                     end
                  end
                  OP_LOCK_SET: next_r.lock = 1'b1;
                  OP_PW_UNLOCK: begin
                     // unlock by software exists only in password mode
                     if (r.pw_mode) begin
                        next_r.state = ST_PWCHK;
                        next_r.cnt   = CHK_CNT;
                     end
                  end
                  OP_PW_PROG: begin
                     if (r.pw_lock) begin
                        next_r.tmo = 1'b1;
                     end else begin
                        next_r.state   = ST_PWPRG;
                        next_r.cnt     = PRG_CNT;
                        next_r.stat_rd = 1'b1;
                     end
                  end
                  OP_PW_MLOCK: begin
                     next_r.pw_mode = 1'b1;
                     next_r.pw_lock = 1'b1;
                  end
                  OP_PROGRAM, OP_ERASE: begin
                     tg = addr_to_group(r.addr);
                     pv = prot_vec(r);
                     if (pv[tg]) begin
                        next_r.denied = 1'b1;
                        next_r.state  = ST_DENY;
                        next_r.cnt    = (r.op == OP_ERASE) ? ERA_CNT : PRG_CNT;
                     end else begin
                        next_r.gnt.grant = 1'b1;
                        next_r.gnt.erase = (r.op == OP_ERASE);
                        next_r.gnt.grp   = tg;
                     end
                  end
                  OP_RD_RESET: next_r.stat_rd = 1'b0;
                  default: ;
               endcase
            end
         end
         ST_PWCHK: begin
            // the fixed wait slows exhaustive guessing
            if (r.cnt == '0) begin
               next_r.state = ST_IDLE;
               if (r.pwd_in == r.pw) begin
                  next_r.lock = 1'b0;
               end
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         ST_PWPRG: begin
            if (r.cnt == '0) begin
               next_r.state = ST_IDLE;
               next_r.pw    = r.pw & r.pwd_in;
               next_r.tmo   = |(~r.pw & r.pwd_in);
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         ST_DENY: begin
            if (r.cnt == '0) begin
               next_r.state = ST_IDLE;
            end else begin
               next_r.cnt = r.cnt - 1'b1;
            end
         end
         default: next_r.state = ST_IDLE;
      endcase

      // hardware reset pin clears dynamic bits, engine, pending command and status mode; lock loads pw_mode
      rst_lo = !r.s2[PIN_RS];
      if (rst_lo) begin
         next_r.dyn     = BITS_RESET;
         next_r.lock    = r.pw_mode;
         next_r.state   = ST_IDLE;
         next_r.cnt     = '0;
         next_r.pend    = 1'b0;
         next_r.stat_rd = 1'b0;
         next_r.gnt.grant = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // power-up: persistent bits, lock, mode as delivered
         r         <= '0;
         r.s1      <= 5'h1f;
         r.s2      <= 5'h1f;
         r.we_q    <= 1'b1;
         r.pu_inh  <= 1'b1;
         r.state   <= ST_IDLE;
         r.op      <= OP_NONE;
         r.pw      <= PW_RESET;
         r.dyn     <= BITS_RESET;
         r.pers    <= BITS_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign prdata           = r.prdata;
   assign pready           = r.pready;
   assign pslverr          = r.pslverr;
   assign op_grant         = r.gnt.grant;
   assign op_erase         = r.gnt.erase;
   assign op_group         = r.gnt.grp;
   assign status_poll      = (r.state != ST_IDLE) ? 1'b1 : 1'b0;
   assign status_read_mode = r.stat_rd;
endmodule : swp_sector_protect
`default_nettype wire

// ---- pkg/swp_pkg.sv ----
// swp_pkg: constants, types and the register map of the sector write protection block
package swp_pkg;
   localparam int unsigned NUM_GROUPS     = 32;
   localparam int unsigned GRP_W          = 5;
   localparam int unsigned ADDR_W         = 20;
   localparam int unsigned PW_W           = 64;
   // register byte offsets
   localparam logic [7:0]  OFS_CMD        = 8'h00;
   localparam logic [7:0]  OFS_ADDR       = 8'h04;
   localparam logic [7:0]  OFS_PWD_LO     = 8'h08;
   localparam logic [7:0]  OFS_PWD_HI     = 8'h0c;
   localparam logic [7:0]  OFS_STATUS     = 8'h10;
   localparam logic [7:0]  OFS_DYN        = 8'h14;
   localparam logic [7:0]  OFS_PERS       = 8'h18;
   localparam logic [7:0]  OFS_PROT       = 8'h1c;
   localparam logic [7:0]  OFS_PWRD_LO    = 8'h20;
   localparam logic [7:0]  OFS_PWRD_HI    = 8'h24;
   // command register fields
   localparam int unsigned CMD_OP_LSB     = 0;
   localparam int unsigned CMD_GRP_LSB    = 8;
   // status register bit positions
   localparam int unsigned ST_BUSY        = 0;
   localparam int unsigned ST_POLL        = 1;
   localparam int unsigned ST_DENIED      = 2;
   localparam int unsigned ST_TIMEOUT     = 3;
   localparam int unsigned ST_LOCK        = 4;
   localparam int unsigned ST_PW_MODE     = 5;
   localparam int unsigned ST_PW_LOCK     = 6;
   localparam int unsigned ST_STAT_RD     = 7;
   localparam int unsigned ST_PU_INH      = 8;
   localparam int unsigned ST_PEND        = 9;
   // reset values
   localparam logic [PW_W-1:0]       PW_RESET   = 64'hffff_ffff_ffff_ffff;
   localparam logic [NUM_GROUPS-1:0] BITS_RESET = 32'h0000_0000;
   // address map of sector groups
   localparam logic [ADDR_W-1:0] BOOT_END     = 20'h10000;
   localparam logic [GRP_W-1:0]  MAIN_GRP_OFS = 5'h07;
   localparam logic [GRP_W-1:0]  WP_GRP_A     = 5'h00;
   localparam logic [GRP_W-1:0]  WP_GRP_B     = 5'h01;
   // timing
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned PW_CHECK_NS    = 2000;
   localparam int unsigned PROG_POLL_NS   = 1000;
   localparam int unsigned ERASE_POLL_NS  = 50000;
   localparam int unsigned PW_CHECK_CYC   = (PW_CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PROG_POLL_CYC  = PROG_POLL_NS / CLK_PERIOD_NS;
   localparam int unsigned ERASE_POLL_CYC = ERASE_POLL_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W          = 13;
   // pin vector positions
   localparam int unsigned PIN_CE = 0;
   localparam int unsigned PIN_WE = 1;
   localparam int unsigned PIN_OE = 2;
   localparam int unsigned PIN_WP = 3;
   localparam int unsigned PIN_RS = 4;
   localparam int unsigned NPINS  = 5;

   typedef enum logic [3:0] {
      OP_NONE      = 4'h0,
      OP_DYN_SET   = 4'h1,
      OP_DYN_CLR   = 4'h2,
      OP_PERS_PROG = 4'h3,
      OP_PERS_ERA  = 4'h4,
      OP_LOCK_SET  = 4'h5,
      OP_PW_UNLOCK = 4'h6,
      OP_PW_PROG   = 4'h7,
      OP_PW_MLOCK  = 4'h8,
      OP_PROGRAM   = 4'h9,
      OP_ERASE     = 4'ha,
      OP_RD_RESET  = 4'hf
   } swp_op_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_PWCHK = 4'b0010,
      ST_DENY  = 4'b0100,
      ST_PWPRG = 4'b1000
   } swp_state_t;

   typedef struct packed {
      logic              grant;
      logic              erase;
      logic [GRP_W-1:0]  grp;
   } swp_grant_t;

   typedef struct packed {
      logic [NPINS-1:0]       s1;
      logic [NPINS-1:0]       s2;
      logic                   we_q;
      logic                   pu_inh;
      swp_state_t             state;
      logic [CNT_W-1:0]       cnt;
      swp_op_t                op;
      logic [GRP_W-1:0]       cgrp;
      logic                   pend;
      logic [ADDR_W-1:0]      addr;
      logic [PW_W-1:0]        pwd_in;
      logic [PW_W-1:0]        pw;
      logic [NUM_GROUPS-1:0]  dyn;
      logic [NUM_GROUPS-1:0]  pers;
      logic                   lock;
      logic                   pw_mode;
      logic                   pw_lock;
      logic                   stat_rd;
      logic                   denied;
      logic                   tmo;
      swp_grant_t             gnt;
      logic [31:0]            prdata;
      logic                   pready;
      logic                   pslverr;
   } swp_regs_t;
endpackage : swp_pkg

// ---- sim/swp_host_model.sv ----
// swp_host_model: host side of the flash control pins
`timescale 1ns/1ns
`default_nettype none
module swp_host_model (
   input  wire logic pclk,
   output var  logic ce_n,
   output var  logic we_n,
   output var  logic oe_n,
   output var  logic wp_n,
   output var  logic reset_pin_n
);
   initial begin
      {ce_n, we_n, oe_n, wp_n, reset_pin_n} = 5'h1f;
   end
   // oe low on purpose shows the write inhibit; hold sets a slow host
   task automatic wcycle(input logic oe, input int hold);
      @(posedge pclk); ce_n <= 1'b0; oe_n <= oe;
      @(posedge pclk); we_n <= 1'b0;
      repeat (hold + 2) @(posedge pclk);
      we_n <= 1'b1;
      @(posedge pclk); ce_n <= 1'b1; oe_n <= 1'b1;
   endtask : wcycle
   // only between sequences, never floating
   task automatic set_wp(input logic v);
      @(posedge pclk); wp_n <= v;
   endtask : set_wp
   task automatic hw_reset;
      @(posedge pclk); reset_pin_n <= 1'b0;
      repeat (4) @(posedge pclk);
      reset_pin_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : hw_reset
endmodule : swp_host_model
`default_nettype wire

// ---- sim/swp_monitor.sv ----
// swp_monitor: port-level assertions for the sector protection block
`timescale 1ns/1ns
`default_nettype none
module swp_monitor #(
   parameter int unsigned ERASE_POLL = 20
) (
   input wire logic                      pclk,
   input wire logic                      presetn,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire logic                      ce_n,
   input wire logic                      oe_n,
   input wire logic                      wp_n,
   input wire logic                      op_grant,
   input wire logic [swp_pkg::GRP_W-1:0] op_group,
   input wire logic                      status_poll,
   input wire logic                      status_read_mode
);
   import swp_pkg::*;
   logic [15:0] run;
   // length of the current busy stretch, read back when it ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) run <= 16'h0;
      else run <= status_poll ? run + 16'h1 : 16'h0;
   end
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   wait_state_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after access phase");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
   grant_pulse_a: assert property (op_grant |=> !op_grant) else $error("grant held");
   wp_guard_a: assert property (((!wp_n)[*6] ##0 op_grant) |-> op_group > 5'h01)
      else $error("boot group granted with wp low");
   ce_inhibit_a: assert property (ce_n[*8] |-> !op_grant) else $error("grant without ce");
   oe_inhibit_a: assert property ((!oe_n)[*8] |-> !op_grant) else $error("grant with oe low");
   rdmode_poll_a: assert property ($rose(status_read_mode) |-> ##[0:2] status_poll)
      else $error("status mode without busy");
   poll_len_a: assert property ($fell(status_poll) |->
      run inside {[99:101], [199:201], [ERASE_POLL-1:ERASE_POLL+1]})
      else $error("busy stretch of wrong length");
endmodule : swp_monitor
bind swp_sector_protect swp_monitor #(.ERASE_POLL(ERASE_POLL)) swp_monitor_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .ce_n(ce_n), .oe_n(oe_n), .wp_n(wp_n), .op_grant(op_grant),
   .op_group(op_group), .status_poll(status_poll), .status_read_mode(status_read_mode));
`default_nettype wire

// ---- sim/testbench.sv ----
// testbench: self-checking bench of the sector write protection block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import swp_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic              ce_n, we_n, oe_n, wp_n, reset_pin_n, op_grant, op_erase;
   logic              status_poll, status_read_mode, m_lock, m_pwm, m_tmo, m_srd;
   logic              last_erase;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, r, m_dyn, m_pers;
   logic [GRP_W-1:0]  op_group, last_grp;
   logic [19:0]       ad;
   logic [63:0]       m_pw, m_pin;
   int                failures, comparisons, seed, grants, k;
   swp_op_t           ops [4] = '{OP_DYN_SET, OP_DYN_CLR, OP_PERS_PROG, OP_PERS_ERA};

   swp_sector_protect #(.ERASE_POLL(20)) swp_sector_protect_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
      .we_n(we_n), .oe_n(oe_n), .wp_n(wp_n), .reset_pin_n(reset_pin_n),
      .op_grant(op_grant), .op_erase(op_erase), .op_group(op_group),
      .status_poll(status_poll), .status_read_mode(status_read_mode));
   swp_host_model swp_host_model_inst (.pclk(pclk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .wp_n(wp_n), .reset_pin_n(reset_pin_n));

   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (op_grant === 1'b1) begin
         grants <= grants + 1;
         last_grp <= op_group;
         last_erase <= op_erase;
      end
   end

   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) chk("pready", 1, 0);
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic verify;
      apb(0, OFS_DYN, 0, r, err); chk("dyn", m_dyn, r);
      apb(0, OFS_PERS, 0, r, err); chk("pers", m_pers, r);
      apb(0, OFS_PROT, 0, r, err); chk("prot", m_dyn | m_pers | {30'h0, {2{~wp_n}}}, r);
      apb(0, OFS_STATUS, 0, r, err);
      chk("status", {m_pwm, m_lock, m_tmo, m_srd},
          {r[ST_PW_MODE], r[ST_LOCK], r[ST_TIMEOUT], r[ST_STAT_RD]});
      chk("rdmode", m_srd, status_read_mode);
   endtask : verify

   task automatic setpw(input logic [63:0] v);
      apb(1, OFS_PWD_LO, v[31:0], r, err);
      apb(1, OFS_PWD_HI, v[63:32], r, err);
      m_pin = v;
   endtask : setpw

   task automatic readpw(input logic [63:0] e);
      logic [31:0] lo;
      apb(0, OFS_PWRD_LO, 0, lo, err);
      apb(0, OFS_PWRD_HI, 0, r, err);
      chk("password", e, {r, lo});
   endtask : readpw

   task automatic cmd(input swp_op_t op, input logic [4:0] g, input logic [19:0] a,
                      input logic bad);
      int g0;
      int n;
      logic [4:0] tg;
      logic eg;
      apb(1, OFS_ADDR, {12'h0, a}, r, err);
      apb(1, OFS_CMD, {19'h0, g, 4'h0, op}, r, err);
      tg = a < 20'h10000 ? {2'b00, a[15:13]} : {1'b0, a[19:16]} + 5'h07;
      eg = (op == OP_PROGRAM || op == OP_ERASE) && !(m_dyn[tg] | m_pers[tg] | (!wp_n && tg < 2));
      if (bad) begin
         swp_host_model_inst.wcycle(1'b0, 1);
         repeat (8) @(posedge pclk);
         apb(0, OFS_STATUS, 0, r, err); chk("pending", 1, r[ST_PEND]);
      end
      g0 = grants;
      swp_host_model_inst.wcycle(1'b1, $random(seed) & 3);
      n = 0;
      do apb(0, OFS_STATUS, 0, r, err);
      while ((r[ST_BUSY] | r[ST_PEND] | r[ST_POLL]) !== 1'b0 && ++n < 500);
      if (n >= 500) chk("idle", 0, 1);
      // grant lands one cycle after the command executes
      repeat (3) @(posedge pclk);
      m_tmo = 1'b0;
      case (op)
         OP_DYN_SET:   m_dyn[g] = 1'b1;
         OP_DYN_CLR:   m_dyn[g] = 1'b0;
         OP_PERS_PROG: if (m_lock) m_tmo = 1'b1; else m_pers[g] = 1'b1;
         OP_PERS_ERA:  if (m_lock) m_tmo = 1'b1; else m_pers = '0;
         OP_LOCK_SET:  m_lock = 1'b1;
         OP_PW_UNLOCK: if (m_pwm && m_pin == m_pw) m_lock = 1'b0;
         OP_PW_PROG: begin
            if (m_pwm) m_tmo = 1'b1;
            else begin
               m_tmo = |(~m_pw & m_pin);
               m_pw &= m_pin;
               m_srd = 1'b1;
            end
         end
         OP_PW_MLOCK:  m_pwm = 1'b1;
         OP_RD_RESET:  m_srd = 1'b0;
         default: ;
      endcase
      chk("grant", eg, grants - g0);
      if (eg) chk("group", tg, last_grp);
      if (eg) chk("erase", op == OP_ERASE, last_erase);
      verify();
   endtask : cmd

   task automatic final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report

   initial begin
      #300000;
      failures++;
      $display("MISMATCH watchdog expected done seen hang");
      final_report();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {failures, comparisons, grants} = '0;
      seed = 6;
      {m_dyn, m_pers, m_lock, m_pwm, m_tmo, m_srd} = '0;
      m_pw = '1;
      m_pin = '1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      verify();
      apb(0, 8'h30, 0, r, err);
      chk("slverr", 1, err);
      chk("unmapped", 0, r);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         k = $random(seed);
         swp_host_model_inst.set_wp(k[4]);
         cmd(ops[k[1:0]], k[9:5], 0, i == 0);
         ad = $random(seed);
         if (k[10]) ad[19:14] = '0;
         cmd(k[11] ? OP_ERASE : OP_PROGRAM, 0, ad, 0);
      end
      $display("test protect done");
      cmd(OP_LOCK_SET, 0, 0, 0);
      cmd(OP_PERS_PROG, 5'h03, 0, 0);
      cmd(OP_PERS_ERA, 0, 0, 0);
      cmd(OP_DYN_SET, 5'h03, 0, 0);
      swp_host_model_inst.hw_reset();
      m_dyn = '0;
      m_lock = m_pwm;
      verify();
      $display("test lock done");
      setpw({$random(seed), $random(seed)});
      cmd(OP_PW_PROG, 0, 0, 0);
      cmd(OP_RD_RESET, 0, 0, 0);
      setpw('1);
      cmd(OP_PW_PROG, 0, 0, 0);
      cmd(OP_RD_RESET, 0, 0, 0);
      readpw(m_pw);
      cmd(OP_PW_MLOCK, 0, 0, 0);
      readpw(64'h0);
      swp_host_model_inst.hw_reset();
      m_dyn = '0;
      m_lock = m_pwm;
      verify();
      setpw(m_pw ^ 64'h1);
      cmd(OP_PW_UNLOCK, 0, 0, 0);
      setpw(m_pw);
      cmd(OP_PW_UNLOCK, 0, 0, 0);
      setpw(64'h0);
      cmd(OP_PW_PROG, 0, 0, 0);
      readpw(64'h0);
      $display("test password done");
      final_report();
   end
endmodule : testbench
`default_nettype wire
